// ### uart_half_duplex_tx_rx_gating_test.sv
// Self-checking bench of the half-duplex UART channel
`timescale 1ns/1ps
module uart_half_duplex_tx_rx_gating_test;
    import uhd_pkg::*;
    localparam int BC = 8;
    logic        clk_sys, rst_n, psel, penable, pwrite, rxd, hd, fsel, inv;
    logic [7:0]  paddr, v;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, txd, rts_n, dtr_n, tx_ready_irq, sel_pin, oth_pin;
    int          n_mismatch = 0;
    int          compares = 0;
    int          c;
    logic [32:0] rq[$];
    logic [7:0]  tq[$];
    logic [7:0]  rb[3];
    assign sel_pin = fsel ? dtr_n : rts_n;
    assign oth_pin = fsel ? rts_n : dtr_n;
    uhd_uart_ctl #(.BIT_CLKS(BC), .DEPTH(16)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxd(rxd), .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n), .tx_ready_irq(tx_ready_irq));
    uhd_line_model #(.BIT_CLKS(BC)) line (.clk_sys(clk_sys), .dir(hd & sel_pin), .inv(inv), .rxd(rxd));
    // ====================================
    // Checking and verdict
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic results;
        if (n_mismatch == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    // ====================================
    // APB master
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic err);
        rq.push_back({err, 24'h0, e});
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic drain;
        for (int i = 0; i < 400 && tq.size() > 0; i++) @(posedge clk_sys);
        chk(tq.size(), 0);
    endtask : drain
    // ====================================
    // Monitors: read data and serial frames against oldest note
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, rq.size() ? rq.pop_front() : 'x);
    end
    initial begin
        logic [7:0] b;
        forever begin
            @(negedge txd);
            repeat (BC / 2) @(posedge clk_sys);
            for (int i = 0; i < 8; i++) begin
                repeat (BC) @(posedge clk_sys);
                b[i] = txd;
            end
            repeat (BC) @(posedge clk_sys);
            chk(txd, 1'b1);
            chk(b, tq.size() ? {25'h0, tq.pop_front()} : 'x);
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #400000;
        n_mismatch++;
        results();
    end
    // ====================================
    // Main sequence
    initial begin
        void'($urandom(16));
        {rst_n, psel, penable, pwrite, paddr, pwdata, hd, fsel, inv} = '0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(ADR_SCR, SCR_RST, 1'b0);
        rd(ADR_GATE, REG_RST, 1'b0);
        rd(8'h20, 8'h00, 1'b1);
        v = 8'($urandom);
        wr(ADR_SCR, v);
        rd(ADR_SCR, v, 1'b0);
        for (int t = 0; t < 4; t++) begin
            wr(ADR_FEAT, 8'(t << FT_TBL_LSB));
            rd(ADR_FEAT, 8'(t << FT_TBL_LSB), 1'b0);
        end
        wr(ADR_GATE, 8'h08);
        v = 8'($urandom);
        tq.push_back(v);
        wr(ADR_DATA, v);
        repeat (40) @(posedge clk_sys);
        chk(tx_ready_irq, 1'b1);
        drain();
        wr(ADR_EFC, 8'h10);
        wr(ADR_GATE, 8'h08);
        v = 8'($urandom);
        wr(ADR_DATA, v);
        repeat (200) @(posedge clk_sys);
        tq.push_back(v);
        wr(ADR_GATE, 8'h00);
        drain();
        for (int k = 0; k < 3; k++) begin
            rb[k] = 8'($urandom);
            if (k == 1) wr(ADR_GATE, 8'h04);
            if (k == 2) wr(ADR_GATE, 8'h00);
            line.send(rb[k]);
            repeat (BC * 2) @(posedge clk_sys);
            if (k == 1) rd(ADR_DATA, rb[0], 1'b0);
            if (k != 0) rd(ADR_DATA, (k == 1) ? 8'h00 : rb[2], 1'b0);
        end
        rb[0] = 8'($urandom);
        inv <= 1'b1;
        wr(ADR_FEAT, 8'h10);
        repeat (BC * 2) @(posedge clk_sys);
        line.send(rb[0]);
        repeat (BC * 2) @(posedge clk_sys);
        rd(ADR_DATA, rb[0], 1'b0);
        inv <= 1'b0;
        wr(ADR_FEAT, 8'h00);
        wr(ADR_EFC, 8'h50);
        wr(ADR_FEAT, 8'h20);
        hd <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            fsel <= k[0];
            wr(ADR_MLC, {5'h0, k[0], 2'b11});
            wr(ADR_GATE, 8'((k * 5) << GT_DLY_LSB));
            v = 8'($urandom);
            tq.push_back(v);
            wr(ADR_DATA, v);
            repeat (40) @(posedge clk_sys);
            chk(tx_ready_irq, 1'b0);
            chk({sel_pin, oth_pin}, 2'b10);
            for (c = 40; sel_pin !== 1'b0 && c < 400; c++) @(posedge clk_sys);
            chk(c >= 80 + 40 * k && c <= 86 + 40 * k, 1'b1);
        end
        drain();
        results();
    end
endmodule : uart_half_duplex_tx_rx_gating_test

// ### uhd_line_model.sv
// Half-duplex line transceiver with remote station
`timescale 1ns/1ps
module uhd_line_model #(
    parameter int BIT_CLKS = 8
) (
    input  wire logic clk_sys,
    input  wire logic dir,
    input  wire logic inv,
    output logic      rxd
);
    logic remote;
    // Receiver off while local driver owns line; pull-up wins
    // Inverted infrared line idles low
    assign rxd = dir ? 1'b1 : remote ^ inv;
    // Remote idles high between frames
    initial remote = 1'b1;
    // ====================================
    // Remote send, 8N1 LSB first
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            remote <= f[i];
            repeat (BIT_CLKS) @(posedge clk_sys);
        end
    endtask : send
endmodule : uhd_line_model

// ### uhd_pkg.sv
// Package: register map, field positions and encodings of the half-duplex UART channel
package uhd_pkg;
    // Register byte addresses
    localparam logic [7:0] ADR_DATA = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_GATE = 8'h08;
    localparam logic [7:0] ADR_SCR  = 8'h0c;
    localparam logic [7:0] ADR_FEAT = 8'h10;
    localparam logic [7:0] ADR_EFC  = 8'h14;
    localparam logic [7:0] ADR_MLC  = 8'h18;
    localparam logic [7:0] ADR_TRIG = 8'h1c;
    // line_turnaround_and_gating_control fields
    localparam int GT_DLY_LSB = 4;
    localparam int GT_TX_DIS  = 3;
    localparam int GT_RX_DIS  = 2;
    localparam int GT_TX_MODE = 1;
    localparam int GT_RX_MODE = 0;
    // feature_control fields
    localparam int FT_TBL_LSB = 6;
    localparam int FT_RS485   = 5;
    localparam int FT_IR_INV  = 4;
    // enhanced_feature_control fields
    localparam int EF_AUTO_RTS = 6;
    localparam int EF_ENH      = 4;
    // modem_line_control fields
    localparam int MC_FSEL = 2;
    localparam int MC_RTS  = 1;
    localparam int MC_DTR  = 0;
    // Reset values
    localparam logic [7:0] SCR_RST  = 8'hff;
    localparam logic [7:0] REG_RST  = 8'h00;
    localparam logic [7:0] TRIG_RST = 8'h08;
    // Flow-control characters
    localparam logic [7:0] XON_CHAR  = 8'h11;
    localparam logic [7:0] XOFF_CHAR = 8'h13;
    // Frame: start, eight data, stop
    localparam logic [3:0] LAST_BIT = 4'h9;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SEND = 2'b01,
        TX_TURN = 2'b10
    } uhd_tx_st_t;
endpackage : uhd_pkg

// ### uhd_uart_ctl.sv
// Half-duplex UART channel with transmit/receive gating, APB registers
//
// Functional notes
// - Upper nibble of gating register sets turnaround delay of 0..15 bit times.
// - Turnaround delay field writable only while enhanced write enable is one.
// - Transmitter disable stops data loads after the current frame; queued and new bytes stay in FIFO.
// - Clearing transmitter disable resumes sending the queued bytes.
// - Receiver disable finishes current character, then accepts no more.
// - Re-enable receiver while line idle; next character is received normally.
// - Receive FIFO stays readable whatever the receiver disable setting.
// - Transmit mode bit: zero sends only pending flow characters, one keeps sending.
// - Receive mode bit: zero ignores everything, one still acts on flow characters.
// - Eight-bit scratch register, read/write, resets to all ones.
// - Table select; tables A-C move request line 2, 4 or 8 levels around trigger.
// - Enable bit turns on direction control on the flow-selected modem output.
// - Direction control overrides automatic receive flow control on that output.
// - Direction output falls after last stop bit plus turnaround delay.
// - Direction output rises when a byte enters the transmit FIFO.
// - Transmit ready event follows FIFO empty, or shifter empty in direction mode.
// - Flow characters sent with empty FIFO leave the direction output unchanged.
// - Polarity bit selects normal or inverted infrared receive data.
// - Flow select zero picks request-to-send, one picks terminal-ready.
// - Enhanced write enable gates the whole gating register; enhanced bits reset zero.
`timescale 1ns/1ps
module uhd_uart_ctl #(
    parameter int BIT_CLKS = 868,
    parameter int DEPTH    = 16
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxd,
    output logic             txd,
    output logic             rts_n,
    output logic             dtr_n,
    output logic             tx_ready_irq
);
    import uhd_pkg::*;

    localparam int         LW       = $clog2(DEPTH);
    localparam logic [LW:0] FULL_LV = (LW+1)'(DEPTH);
    localparam logic [11:0] BIT_TOP = 12'(BIT_CLKS - 1);
    localparam logic [11:0] HALF_TOP = 12'(BIT_CLKS / 2 - 1);

    function automatic logic known(input logic [7:0] a);
        return a inside {ADR_DATA, ADR_STAT, ADR_GATE, ADR_SCR, ADR_FEAT, ADR_EFC, ADR_MLC, ADR_TRIG};
    endfunction : known

    function automatic logic pin_val(input logic rs485, input logic dir, input logic ctl, input logic stop);
        return rs485 ? dir : (~ctl | stop);
    endfunction : pin_val

    // ==================================================================
    // Register bus
    logic [7:0]   gate;
    logic [7:0]   scratch;
    logic [7:0]   feat;
    logic [7:0]   efc;
    logic [7:0]   mlc;
    logic [7:0]   trig;
    logic         acc;
    logic         wr_acc;
    logic         rd_acc;
    logic [7:0]   stat;
    logic [31:0]  next_prdata;

    assign acc    = psel & penable & pready;
    assign wr_acc = acc & pwrite;
    assign rd_acc = acc & ~pwrite;

    // One wait state per access
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            if (psel & penable & ~pready) begin
                pslverr <= ~known(paddr);
                prdata  <= next_prdata;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scratch <= SCR_RST;
            feat    <= REG_RST;
            efc     <= REG_RST;
            mlc     <= REG_RST;
            trig    <= TRIG_RST;
        end else if (wr_acc) begin
            if (paddr == ADR_SCR) scratch <= pwdata[7:0];
            if (paddr == ADR_FEAT) feat <= pwdata[7:0];
            if (paddr == ADR_EFC) efc <= pwdata[7:0];
            if (paddr == ADR_MLC) mlc <= pwdata[7:0];
            if (paddr == ADR_TRIG) trig <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gate <= REG_RST;
        end else if (wr_acc && paddr == ADR_GATE && efc[EF_ENH]) begin
            gate <= pwdata[7:0];
        end
    end

    // ==================================================================
    // FIFOs
    logic [7:0]  txf_mem [DEPTH];
    logic [7:0]  rxf_mem [DEPTH];
    logic [LW:0] txf_wp;
    logic [LW:0] txf_rp;
    logic [LW:0] rxf_wp;
    logic [LW:0] rxf_rp;
    logic [LW:0] rxl;
    logic        txf_empty;
    logic        txf_full;
    logic        rxf_empty;
    logic        rxf_full;
    logic        txf_push;
    logic        rxf_pop;
    logic        rx_push;
    logic        tx_load_data;
    logic        tx_load_ctl;
    logic [7:0]  rx_sh;

    assign txf_empty = txf_wp == txf_rp;
    assign txf_full  = (txf_wp - txf_rp) == FULL_LV;
    assign rxl       = rxf_wp - rxf_rp;
    assign rxf_empty = rxl == '0;
    assign rxf_full  = rxl == FULL_LV;
    assign txf_push  = wr_acc && paddr == ADR_DATA && !txf_full;
    assign rxf_pop   = rd_acc && paddr == ADR_DATA && !rxf_empty;

    always_ff @(posedge clk_sys) begin
        if (txf_push) txf_mem[txf_wp[LW-1:0]] <= pwdata[7:0];
        if (rx_push) rxf_mem[rxf_wp[LW-1:0]] <= rx_sh;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            txf_wp <= '0;
            txf_rp <= '0;
            rxf_wp <= '0;
            rxf_rp <= '0;
        end else begin
            if (txf_push) txf_wp <= txf_wp + 1'b1;
            if (tx_load_data) txf_rp <= txf_rp + 1'b1;
            if (rx_push) rxf_wp <= rxf_wp + 1'b1;
            if (rxf_pop) rxf_rp <= rxf_rp + 1'b1;
        end
    end

    // ==================================================================
    // Flow-control levels
    logic [7:0] step;
    logic [8:0] up_lv;
    logic [7:0] lo_lv;
    logic [7:0] rxl8;
    logic       flow_stop;
    logic       off_sent;
    logic       xoff_pend;
    logic       xon_pend;
    logic       gen_ok;
    logic       rem_stop;

    assign rxl8 = 8'(rxl);

    // Tables A-C: 2, 4 or 8 levels around trigger; table D hysteresis not held here
    always_comb begin
        unique case (feat[FT_TBL_LSB+1:FT_TBL_LSB])
            2'b00: step = 8'h02;
            2'b01: step = 8'h04;
            2'b10: step = 8'h08;
            2'b11: step = 8'h00;
        endcase
        up_lv = {1'b0, trig} + {1'b0, step};
        lo_lv = (trig > step) ? trig - step : 8'h00;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flow_stop <= 1'b0;
        end else if (!efc[EF_AUTO_RTS]) begin
            flow_stop <= 1'b0;
        end else if ({1'b0, rxl8} >= up_lv) begin
            flow_stop <= 1'b1;
        end else if (rxl8 < lo_lv) begin
            flow_stop <= 1'b0;
        end
    end

    // New flow characters are generated only if the halt mode allows
    assign gen_ok = (efc[3:2] != 2'b00) & (!gate[GT_TX_DIS] | gate[GT_TX_MODE]);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            off_sent  <= 1'b0;
            xoff_pend <= 1'b0;
            xon_pend  <= 1'b0;
        end else if (efc[3:2] == 2'b00) begin
            off_sent  <= 1'b0;
            xoff_pend <= 1'b0;
            xon_pend  <= 1'b0;
        end else if (gen_ok && !off_sent && rxl8 >= trig) begin
            off_sent  <= 1'b1;
            xoff_pend <= 1'b1;
            xon_pend  <= 1'b0;
        end else if (gen_ok && off_sent && rxl8 < lo_lv) begin
            off_sent  <= 1'b0;
            xon_pend  <= 1'b1;
            xoff_pend <= 1'b0;
        end else if (tx_load_ctl) begin
            if (xoff_pend) xoff_pend <= 1'b0;
            else xon_pend <= 1'b0;
        end
    end

    // ==================================================================
    // Transmitter
    uhd_tx_st_t tx_st;
    logic [11:0] tx_baud;
    logic [3:0]  tx_bit;
    logic [9:0]  tx_sh;
    logic        cur_data;
    logic [3:0]  turn_cnt;
    logic        tx_tick;
    logic        frame_end;
    logic        can_start;
    logic        data_go;
    logic        dir_on;
    logic [3:0]  dly;
    logic [7:0]  tx_char;

    assign dly       = gate[GT_DLY_LSB+3:GT_DLY_LSB];
    assign tx_tick   = tx_baud == BIT_TOP;
    assign frame_end = (tx_st == TX_SEND) & tx_tick & (tx_bit == LAST_BIT);
    assign can_start = (tx_st == TX_IDLE) | (tx_st == TX_TURN) | frame_end;
    assign data_go   = !txf_empty & !gate[GT_TX_DIS] & !rem_stop;
    assign tx_load_ctl  = can_start & (xoff_pend | xon_pend);
    assign tx_load_data = can_start & !(xoff_pend | xon_pend) & data_go;
    assign tx_char   = tx_load_ctl ? (xoff_pend ? XOFF_CHAR : XON_CHAR) : txf_mem[txf_rp[LW-1:0]];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_st    <= TX_IDLE;
            tx_baud  <= 12'h000;
            tx_bit   <= 4'h0;
            tx_sh    <= 10'h3ff;
            cur_data <= 1'b0;
            turn_cnt <= 4'h0;
        end else if (tx_load_ctl | tx_load_data) begin
            tx_st    <= TX_SEND;
            tx_baud  <= 12'h000;
            tx_bit   <= 4'h0;
            tx_sh    <= {1'b1, tx_char, 1'b0};
            cur_data <= tx_load_data;
        end else begin
            unique case (tx_st)
                TX_IDLE: begin
                    tx_baud <= 12'h000;
                end
                TX_SEND: begin
                    if (tx_tick) begin
                        tx_baud <= 12'h000;
                        tx_bit  <= tx_bit + 4'h1;
                        tx_sh   <= {1'b1, tx_sh[9:1]};
                        if (tx_bit == LAST_BIT) begin
                            if (feat[FT_RS485] && cur_data && dly != 4'h0) begin
                                tx_st    <= TX_TURN;
                                turn_cnt <= dly;
                            end else begin
                                tx_st <= TX_IDLE;
                            end
                        end
                    end else begin
                        tx_baud <= tx_baud + 12'h001;
                    end
                end
                TX_TURN: begin
                    if (tx_tick) begin
                        tx_baud  <= 12'h000;
                        turn_cnt <= turn_cnt - 4'h1;
                        if (turn_cnt == 4'h1) tx_st <= TX_IDLE;
                    end else begin
                        tx_baud <= tx_baud + 12'h001;
                    end
                end
                default: tx_st <= TX_IDLE;
            endcase
        end
    end

    // Direction high while data is queued, sent or turning around
    assign dir_on = (tx_st == TX_SEND & cur_data) | (tx_st == TX_TURN) | !txf_empty;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            txd          <= 1'b1;
            rts_n        <= 1'b1;
            dtr_n        <= 1'b1;
            tx_ready_irq <= 1'b1;
        end else begin
            txd <= (tx_st == TX_SEND) ? tx_sh[0] : 1'b1;
            rts_n <= mlc[MC_FSEL] ? ~mlc[MC_RTS] :
                     pin_val(feat[FT_RS485], dir_on, mlc[MC_RTS], efc[EF_AUTO_RTS] & flow_stop);
            dtr_n <= !mlc[MC_FSEL] ? ~mlc[MC_DTR] :
                     pin_val(feat[FT_RS485], dir_on, mlc[MC_DTR], efc[EF_AUTO_RTS] & flow_stop);
            tx_ready_irq <= feat[FT_RS485] ? (txf_empty & tx_st != TX_SEND) : txf_empty;
        end
    end

    // ==================================================================
    // Receiver
    logic        rx_s1;
    logic        rx_s2;
    logic        rx_in;
    logic        rx_prev;
    logic        rx_busy;
    logic        rx_keep;
    logic [11:0] rx_baud;
    logic [3:0]  rx_bit;
    logic        rx_smp;
    logic        rx_done;
    logic        is_flow;
    logic        flow_seen;

    assign rx_in   = rx_s2 ^ feat[FT_IR_INV];
    assign rx_smp  = rx_baud == ((rx_bit == 4'h0) ? HALF_TOP : BIT_TOP);
    assign rx_done = rx_busy & rx_smp & (rx_bit == LAST_BIT);
    assign is_flow = (efc[1:0] != 2'b00) & (rx_sh == XON_CHAR | rx_sh == XOFF_CHAR);
    assign rx_push = rx_done & rx_keep & !is_flow & !rxf_full;
    assign flow_seen = rx_done & (efc[1:0] != 2'b00) & (rx_keep | gate[GT_RX_MODE]);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_s1   <= 1'b1;
            rx_s2   <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_s1   <= rxd;
            rx_s2   <= rx_s1;
            rx_prev <= rx_in;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_busy <= 1'b0;
            rx_keep <= 1'b0;
            rx_baud <= 12'h000;
            rx_bit  <= 4'h0;
            rx_sh   <= 8'h00;
        end else if (!rx_busy) begin
            rx_baud <= 12'h000;
            rx_bit  <= 4'h0;
            // Start only on an idle-to-low edge while running is allowed
            if (rx_prev && !rx_in && (!gate[GT_RX_DIS] || gate[GT_RX_MODE])) begin
                rx_busy <= 1'b1;
                rx_keep <= !gate[GT_RX_DIS];
            end
        end else if (rx_smp) begin
            rx_baud <= 12'h000;
            rx_bit  <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && rx_in) rx_busy <= 1'b0;
            if (rx_bit != 4'h0 && rx_bit != LAST_BIT) rx_sh <= {rx_in, rx_sh[7:1]};
            if (rx_bit == LAST_BIT) rx_busy <= 1'b0;
        end else begin
            rx_baud <= rx_baud + 12'h001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rem_stop <= 1'b0;
        end else if (efc[1:0] == 2'b00) begin
            rem_stop <= 1'b0;
        end else if (flow_seen && rx_sh == XOFF_CHAR) begin
            rem_stop <= 1'b1;
        end else if (flow_seen && rx_sh == XON_CHAR) begin
            rem_stop <= 1'b0;
        end
    end

    // ==================================================================
    // Read mux
    assign stat = {tx_ready_irq, txf_empty & tx_st == TX_IDLE, txf_empty, rem_stop,
                   flow_stop, off_sent, rxf_full, !rxf_empty};

    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (paddr)
            ADR_DATA: next_prdata = {24'h000000, rxf_empty ? 8'h00 : rxf_mem[rxf_rp[LW-1:0]]};
            ADR_STAT: next_prdata = {24'h000000, stat};
            ADR_SCR:  next_prdata = {24'h000000, scratch};
            ADR_FEAT: next_prdata = {24'h000000, feat};
            ADR_EFC:  next_prdata = {24'h000000, efc};
            ADR_MLC:  next_prdata = {24'h000000, mlc};
            ADR_TRIG: next_prdata = {24'h000000, trig};
            default:  next_prdata = 32'h0000_0000;
        endcase
    end

    // ==================================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_turn_hold;
        (tx_st == TX_TURN) [*2];
    endsequence

    sequence s_idle_empty;
        (tx_st == TX_IDLE && txf_empty) [*3];
    endsequence

    AST_TX_HALT: assert property (gate[GT_TX_DIS] && !xoff_pend && !xon_pend && tx_st != TX_SEND
        |=> tx_st != TX_SEND && txd)
        else $error("data frame started while transmitter disabled");
    AST_TX_RESUME: assert property (tx_st == TX_IDLE && data_go && !xoff_pend && !xon_pend
        |=> tx_st == TX_SEND && txd == 1'b1 ##1 txd == 1'b0)
        else $error("queued byte not resumed");
    AST_GATE_WE: assert property (!$stable(gate) |-> $past(efc[EF_ENH]))
        else $error("gating register changed without write enable");
    AST_SCRATCH: assert property (wr_acc && paddr == ADR_SCR |=> scratch == $past(pwdata[7:0]))
        else $error("scratch register write lost");
    AST_DIR_RISE: assert property (feat[FT_RS485] && !mlc[MC_FSEL] && txf_push
        |-> ##[1:2] rts_n)
        else $error("direction output did not rise on load");
    AST_TURN_ENTRY: assert property (frame_end && !tx_load_ctl && !tx_load_data && cur_data
        && feat[FT_RS485] && dly != 4'h0 |=> tx_st == TX_TURN && turn_cnt == $past(dly))
        else $error("turnaround delay not started");
    AST_TURN_DIR: assert property (feat[FT_RS485] && !mlc[MC_FSEL] && $stable(feat) ##0 s_turn_hold
        |-> rts_n)
        else $error("direction output fell during turnaround");
    AST_DIR_FALL: assert property (feat[FT_RS485] && !mlc[MC_FSEL] && $stable(feat) && $stable(mlc)
        ##0 s_idle_empty |-> !rts_n)
        else $error("direction output not low after transmission");
    AST_CTL_DIR: assert property (feat[FT_RS485] && !mlc[MC_FSEL] && tx_st == TX_SEND && !cur_data
        && txf_empty && $stable(feat) && $stable(mlc) [*2] |-> !rts_n)
        else $error("flow character moved direction output");
    AST_RX_DROP: assert property (rx_done && !rx_keep |-> !rx_push)
        else $error("character stored while receiver disabled");
    AST_IRQ_SHIFT: assert property (feat[FT_RS485] && tx_st == TX_SEND && $stable(feat)
        |=> !tx_ready_irq)
        else $error("transmit ready raised while shifter busy");

endmodule : uhd_uart_ctl
